/* rtl/key_port_status_unit.sv */
// Port registers, pin controls and status flag of the key controller.
// Assumes CPU strobes are one-cycle pulses synchronous to REF_CLK.
//
// The address map and the strobed register port were chosen for this implementation.
module key_port_status_unit (
  input  wire logic       REF_CLK,
  input  wire logic       RST_N,
  input  wire logic [1:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic       STATUS_TEST_INSTR,
  input  wire logic [3:0] STATUS_TEST_INSTR_OP,
  input  wire logic       HALT,
  input  wire logic [2:0] HALT_OP,
  input  wire logic       STBY_EXIT,
  input  wire logic       TMR_ZERO,
  input  wire logic       TMR_OUT_EN,
  input  wire logic [7:0] SCAN_IN,
  output logic      [7:0] SCAN_OUT,
  output logic            SCAN_OE_N,
  output logic            SCAN_PD,
  input  wire logic [3:0] KEY_IN,
  output logic            KEY_PD,
  input  wire logic       SENSE0_IN,
  output logic            SENSE0_EN,
  output logic            SENSE0_PD,
  input  wire logic       LED_IN,
  output logic            LED_OUT,
  output logic            LED_OE_N,
  output logic            LED_PD,
  output logic            FLAG,
  output logic            STBY_ENTER,
  output logic      [7:0] CARR_CTRL
);
  typedef struct packed {
    logic [7:0] scan_q;
    logic [7:0] carr_q;
    logic [7:0] dir_q;
    logic [7:0] rdata_q;
    logic       flag_q;
    logic       stby_q;
    logic       led_q;
    logic [7:0] pins_q;
  } state_t;

  // Pin control image at reset, worked out from the direction reset
  // value so that the two can never disagree after a reset.
  localparam logic [7:0] PINS_RST = {
    1'b0,
    ~key_port_pkg::DIR_RST[key_port_pkg::DIR_SCAN],
    key_port_pkg::DIR_RST[key_port_pkg::DIR_SPD] &
      ~key_port_pkg::DIR_RST[key_port_pkg::DIR_LED],
    key_port_pkg::DIR_RST[key_port_pkg::DIR_SPD] &
      key_port_pkg::DIR_RST[key_port_pkg::DIR_SENSE0],
    ~key_port_pkg::DIR_RST[key_port_pkg::DIR_LED],
    key_port_pkg::DIR_RST[key_port_pkg::DIR_SENSE0],
    key_port_pkg::DIR_RST[key_port_pkg::DIR_KPD],
    ~key_port_pkg::DIR_RST[key_port_pkg::DIR_SCAN]
  };

  state_t s_q, s_d;
  logic key_hi, sense_hi, sense0_rd, cond, wake;

  // Condition evaluation; off-mode sense pin contributes no level.
  always_comb begin
    key_hi = |KEY_IN;
    sense0_rd = s_q.dir_q[key_port_pkg::DIR_SENSE0] ? SENSE0_IN
                                                    : 1'b1;
    sense_hi = (s_q.dir_q[key_port_pkg::DIR_SENSE0] & SENSE0_IN)
             | LED_IN;
    unique case (STATUS_TEST_INSTR_OP[2:0])
      key_port_pkg::OP_KEY_A,
      key_port_pkg::OP_KEY_B,
      key_port_pkg::OP_KEY_C: cond = key_hi;
      key_port_pkg::OP_TIMER: cond = TMR_ZERO;
      default:                cond = 1'b0;
    endcase
    if (STATUS_TEST_INSTR_OP[key_port_pkg::OP_SENSE]) begin
      cond = cond | sense_hi;
    end
    unique case (HALT_OP)
      key_port_pkg::OP_KEY_A,
      key_port_pkg::OP_KEY_B,
      key_port_pkg::OP_KEY_C: wake = key_hi;
      key_port_pkg::OP_TIMER: wake = TMR_ZERO;
      default:                wake = 1'b0;
    endcase
  end

  // Next state: register writes, read mux, flag and led drive.
  always_comb begin
    s_d = s_q;
    s_d.stby_q = 1'b0;
    if (WR) begin
      unique case (ADDR)
        key_port_pkg::ADDR_SCAN: s_d.scan_q = WDATA;
        key_port_pkg::ADDR_CARR:
          s_d.carr_q = WDATA & key_port_pkg::CARR_WMASK;
        key_port_pkg::ADDR_DIR:
          s_d.dir_q = WDATA & key_port_pkg::DIR_WMASK;
        default: ;
      endcase
    end
    s_d.rdata_q = 8'h00;
    if (RD) begin
      unique case (ADDR)
        key_port_pkg::ADDR_SCAN:
          s_d.rdata_q = s_q.dir_q[key_port_pkg::DIR_SCAN] ? s_q.scan_q
                                                         : SCAN_IN;
        key_port_pkg::ADDR_INP:
          s_d.rdata_q = {KEY_IN, LED_IN, sense0_rd,
                         key_port_pkg::INP_FIXED};
        key_port_pkg::ADDR_CARR: s_d.rdata_q = s_q.carr_q;
        key_port_pkg::ADDR_DIR:  s_d.rdata_q = s_q.dir_q;
        default: ;
      endcase
    end
    // Standby exit takes precedence so a wake is never lost.
    if (STBY_EXIT) begin
      s_d.flag_q = 1'b1;
    end else if (STATUS_TEST_INSTR) begin
      s_d.flag_q = cond;
    end else if (HALT) begin
      if (wake) begin
        s_d.flag_q = 1'b1;
      end else if (s_q.flag_q) begin
        s_d.flag_q = 1'b0;
      end else begin
        s_d.stby_q = 1'b1;
      end
    end
    // Without timer output the indicator idles high.
    s_d.led_q = TMR_OUT_EN ? TMR_ZERO : 1'b1;
    // Pin controls take the direction value being loaded, so a pin turns
    // in the same edge as its control bit and never lags a cycle.
    s_d.pins_q[0] = ~s_d.dir_q[key_port_pkg::DIR_SCAN];
    s_d.pins_q[1] = s_d.dir_q[key_port_pkg::DIR_KPD];
    s_d.pins_q[2] = s_d.dir_q[key_port_pkg::DIR_SENSE0];
    s_d.pins_q[3] = ~s_d.dir_q[key_port_pkg::DIR_LED];
    s_d.pins_q[4] = s_d.dir_q[key_port_pkg::DIR_SPD] &
                    s_d.dir_q[key_port_pkg::DIR_SENSE0];
    s_d.pins_q[5] = s_d.dir_q[key_port_pkg::DIR_SPD] &
                    ~s_d.dir_q[key_port_pkg::DIR_LED];
    s_d.pins_q[6] = ~s_d.dir_q[key_port_pkg::DIR_SCAN];
    s_d.pins_q[7] = 1'b0;
  end

  // State register with asynchronous reset to documented values.
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_q.scan_q  <= key_port_pkg::SCAN_RST;
      s_q.carr_q  <= key_port_pkg::CARR_RST;
      s_q.dir_q   <= key_port_pkg::DIR_RST;
      s_q.rdata_q <= 8'h00;
      s_q.flag_q  <= 1'b0;
      s_q.stby_q  <= 1'b0;
      s_q.led_q   <= 1'b1;
      s_q.pins_q  <= PINS_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Every output is a field of the state register.
  assign RDATA      = s_q.rdata_q;
  assign SCAN_OUT   = s_q.scan_q;
  assign SCAN_OE_N  = s_q.pins_q[0];
  assign SCAN_PD    = s_q.pins_q[6];
  assign KEY_PD     = s_q.pins_q[1];
  assign SENSE0_EN  = s_q.pins_q[2];
  assign LED_OE_N   = s_q.pins_q[3];
  assign SENSE0_PD  = s_q.pins_q[4];
  assign LED_PD     = s_q.pins_q[5];
  assign LED_OUT    = s_q.led_q;
  assign FLAG       = s_q.flag_q;
  assign STBY_ENTER = s_q.stby_q;
  assign CARR_CTRL  = s_q.carr_q;

  // Flag follows the status test result one cycle later.
  property p_status_test_instr;
    @(posedge REF_CLK) disable iff (!RST_N)
      (STATUS_TEST_INSTR && !STBY_EXIT) |=> (FLAG == $past(cond));
  endproperty
  a_status_test_instr: assert property (p_status_test_instr) else $error("flag mismatch");
  property p_exit;
    @(posedge REF_CLK) disable iff (!RST_N) STBY_EXIT |=> FLAG;
  endproperty
  a_exit: assert property (p_exit) else $error("exit flag");
  property p_halt_wake;
    @(posedge REF_CLK) disable iff (!RST_N)
      (HALT && wake && !STATUS_TEST_INSTR) |=> (FLAG && !STBY_ENTER);
  endproperty
  a_halt_wake: assert property (p_halt_wake) else $error("halt wake");
  property p_halt_clr;
    @(posedge REF_CLK) disable iff (!RST_N)
      (HALT && !wake && FLAG && !STATUS_TEST_INSTR && !STBY_EXIT)
      |=> (!FLAG && !STBY_ENTER);
  endproperty
  a_halt_clr: assert property (p_halt_clr) else $error("halt clear");
  property p_scan_rd;
    @(posedge REF_CLK) disable iff (!RST_N)
      (RD && ADDR == key_port_pkg::ADDR_SCAN && !SCAN_OE_N && !WR)
      |=> (RDATA == $past(SCAN_OUT));
  endproperty
  a_scan_rd: assert property (p_scan_rd) else $error("scan read");
  property p_scan_wr;
    @(posedge REF_CLK) disable iff (!RST_N)
      (WR && ADDR == key_port_pkg::ADDR_SCAN) |=> (SCAN_OUT == $past(WDATA));
  endproperty
  a_scan_wr: assert property (p_scan_wr) else $error("scan write");
  property p_inp_rd;
    @(posedge REF_CLK) disable iff (!RST_N)
      (RD && ADDR == key_port_pkg::ADDR_INP)
      |=> (RDATA[7:4] == $past(KEY_IN) && RDATA[1:0] == 2'h3);
  endproperty
  a_inp_rd: assert property (p_inp_rd) else $error("input read");
  property p_pd;
    @(posedge REF_CLK) disable iff (!RST_N)
      !(SCAN_PD && !SCAN_OE_N) && !(LED_PD && !LED_OE_N);
  endproperty
  a_pd: assert property (p_pd) else $error("pull-down on output");

  // Read data are zero in any cycle that does not follow a read.
  property p_rd_idle;
    @(posedge REF_CLK) disable iff (!RST_N)
      !RD |=> (RDATA == 8'h00);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stale read");

  // In input direction the key-scan read returns the pin levels.
  property p_scan_rd_in;
    @(posedge REF_CLK) disable iff (!RST_N)
      (RD && ADDR == key_port_pkg::ADDR_SCAN && SCAN_OE_N)
      |=> (RDATA == $past(SCAN_IN));
  endproperty
  a_scan_rd_in: assert property (p_scan_rd_in) else $error("scan pins");

  // An off-mode sense input always reads as one.
  property p_sense_off;
    @(posedge REF_CLK) disable iff (!RST_N)
      (RD && ADDR == key_port_pkg::ADDR_INP && !SENSE0_EN) |=> RDATA[2];
  endproperty
  a_sense_off: assert property (p_sense_off) else $error("sense off");

  // An input-mode sense pin reads its level.
  property p_sense_on;
    @(posedge REF_CLK) disable iff (!RST_N)
      (RD && ADDR == key_port_pkg::ADDR_INP && SENSE0_EN)
      |=> (RDATA[2] == $past(SENSE0_IN));
  endproperty
  a_sense_on: assert property (p_sense_on) else $error("sense in");

  // The indicator pin level reads back in either direction.
  property p_led_rd;
    @(posedge REF_CLK) disable iff (!RST_N)
      (RD && ADDR == key_port_pkg::ADDR_INP)
      |=> (RDATA[3] == $past(LED_IN));
  endproperty
  a_led_rd: assert property (p_led_rd) else $error("indicator read");

  // Carrier control keeps its fixed bits clear on a write.
  property p_carr_wr;
    @(posedge REF_CLK) disable iff (!RST_N)
      (WR && ADDR == key_port_pkg::ADDR_CARR)
      |=> (CARR_CTRL == ($past(WDATA) & key_port_pkg::CARR_WMASK));
  endproperty
  a_carr_wr: assert property (p_carr_wr) else $error("carrier write");

  // Carrier control reads back what it holds.
  property p_carr_rd;
    @(posedge REF_CLK) disable iff (!RST_N)
      (RD && ADDR == key_port_pkg::ADDR_CARR)
      |=> (RDATA == $past(CARR_CTRL));
  endproperty
  a_carr_rd: assert property (p_carr_rd) else $error("carrier read");

  // A write to the read-only input port changes nothing.
  property p_inp_wr;
    @(posedge REF_CLK) disable iff (!RST_N)
      (WR && ADDR == key_port_pkg::ADDR_INP)
      |=> ($stable(CARR_CTRL) && $stable(SCAN_OUT) && $stable(SCAN_OE_N));
  endproperty
  a_inp_wr: assert property (p_inp_wr) else $error("input port write");

  // A one in the scan bit of the direction control drives the port.
  property p_dir_scan;
    @(posedge REF_CLK) disable iff (!RST_N)
      (WR && ADDR == key_port_pkg::ADDR_DIR)
      |=> (SCAN_OE_N == !$past(WDATA[key_port_pkg::DIR_SCAN]));
  endproperty
  a_dir_scan: assert property (p_dir_scan) else $error("scan dir");

  // The key input pull-downs follow their control bit as a group.
  property p_dir_kpd;
    @(posedge REF_CLK) disable iff (!RST_N)
      (WR && ADDR == key_port_pkg::ADDR_DIR)
      |=> (KEY_PD == $past(WDATA[key_port_pkg::DIR_KPD]));
  endproperty
  a_dir_kpd: assert property (p_dir_kpd) else $error("key pull-down");

  // A one in the sense bit puts the sense input in input mode.
  property p_dir_sense;
    @(posedge REF_CLK) disable iff (!RST_N)
      (WR && ADDR == key_port_pkg::ADDR_DIR)
      |=> (SENSE0_EN == $past(WDATA[key_port_pkg::DIR_SENSE0]));
  endproperty
  a_dir_sense: assert property (p_dir_sense) else $error("sense mode");

  // A one in the indicator bit makes the indicator pin an output.
  property p_dir_led;
    @(posedge REF_CLK) disable iff (!RST_N)
      (WR && ADDR == key_port_pkg::ADDR_DIR)
      |=> (LED_OE_N == !$past(WDATA[key_port_pkg::DIR_LED]));
  endproperty
  a_dir_led: assert property (p_dir_led) else $error("indicator mode");

  // Sense pull-down only while the sense input is in input mode.
  property p_sense_pd;
    @(posedge REF_CLK) disable iff (!RST_N)
      SENSE0_PD |-> SENSE0_EN;
  endproperty
  a_sense_pd: assert property (p_sense_pd) else $error("sense pull");

  // Indicator pull-down only while the indicator pin is an input.
  property p_led_pd;
    @(posedge REF_CLK) disable iff (!RST_N)
      LED_PD |-> LED_OE_N;
  endproperty
  a_led_pd: assert property (p_led_pd) else $error("indicator pull");

  // Scan pull-downs are on exactly while the port is an input.
  property p_scan_pd;
    @(posedge REF_CLK) disable iff (!RST_N)
      SCAN_PD == SCAN_OE_N;
  endproperty
  a_scan_pd: assert property (p_scan_pd) else $error("scan pull");

  // With timer output on, the indicator is high only while stopped.
  property p_led_tmr;
    @(posedge REF_CLK) disable iff (!RST_N)
      TMR_OUT_EN |=> (LED_OUT == $past(TMR_ZERO));
  endproperty
  a_led_tmr: assert property (p_led_tmr) else $error("indicator timer");

  // Without timer output the indicator idles high.
  property p_led_idle;
    @(posedge REF_CLK) disable iff (!RST_N)
      !TMR_OUT_EN |=> LED_OUT;
  endproperty
  a_led_idle: assert property (p_led_idle) else $error("indicator idle");

  // The flag only moves on a test, a halt or a standby exit.
  property p_flag_hold;
    @(posedge REF_CLK) disable iff (!RST_N)
      !(STATUS_TEST_INSTR || HALT || STBY_EXIT) |=> $stable(FLAG);
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag moved");

  // Standby is entered only by a halt that nothing else overrides.
  property p_no_stby;
    @(posedge REF_CLK) disable iff (!RST_N)
      (!HALT || STATUS_TEST_INSTR || STBY_EXIT || wake) |=> !STBY_ENTER;
  endproperty
  a_no_stby: assert property (p_no_stby) else $error("stray standby");

  // A high level on the indicator pin satisfies a test with bit three.
  property p_sense_bit;
    @(posedge REF_CLK) disable iff (!RST_N)
      (STATUS_TEST_INSTR && STATUS_TEST_INSTR_OP[key_port_pkg::OP_SENSE] && LED_IN) |=> FLAG;
  endproperty
  a_sense_bit: assert property (p_sense_bit) else $error("sense test");

  // The timer code sets the flag while the down counter is zero.
  property p_tmr_test;
    @(posedge REF_CLK) disable iff (!RST_N)
      (STATUS_TEST_INSTR && STATUS_TEST_INSTR_OP[2:0] == key_port_pkg::OP_TIMER && TMR_ZERO)
      |=> FLAG;
  endproperty
  a_tmr_test: assert property (p_tmr_test) else $error("timer test");

  // A key code sets the flag while any key input is high.
  property p_key_test;
    @(posedge REF_CLK) disable iff (!RST_N)
      (STATUS_TEST_INSTR && STATUS_TEST_INSTR_OP[2:0] == key_port_pkg::OP_KEY_B && (|KEY_IN))
      |=> FLAG;
  endproperty
  a_key_test: assert property (p_key_test) else $error("key test");
endmodule // key_port_status_unit

/* rtl/key_port_pkg.sv */
// Constants for the key port and status flag unit.
// Assumes a CPU-side register port with one-cycle read latency.
// Notes on behaviour
// - Status test sets flag if selected condition holds, else clears it.
// - Leaving standby sets the status flag.
// - Halt with wake condition true sets flag, no standby entry.
// - Halt with flag set and wake condition false clears flag.
// - Operand low bits pick key-input-high or timer-zero condition.
// - Operand bit three adds either sense pin high to the test.
// - Key-scan read gives pins in input mode, latch in output mode.
// - Key-scan writes always update the output latch.
// - Reset puts key-scan port in output mode with latch all ones.
// - Key-scan pull-downs connect only in input direction.
// - Key input levels read-only in bits 4 to 7 of input port.
// - Control bit 5 enables key input pull-downs, on after reset.
// - Sense input off mode is high impedance and reads one.
// - Control bit 0 selects sense input or off mode, off at reset.
// - Control bit 4 enables both sense pull-downs while they are inputs.
// - Control bit 2 sets indicator direction; pin level reads in bit 3.
// - In output mode the indicator drops pull-down, driven by timer.
// - Reset puts indicator pin in output mode driving high.
// - Reset loads carrier control with 03h and direction control 26h.
// - Direction control bit meanings: one selects input, out, led, pull-ons.
// - With timer output on, indicator low while timer runs, else high.
package key_port_pkg;
  localparam logic [1:0] ADDR_SCAN = 2'h0;
  localparam logic [1:0] ADDR_INP  = 2'h1;
  localparam logic [1:0] ADDR_CARR = 2'h2;
  localparam logic [1:0] ADDR_DIR  = 2'h3;
  localparam logic [7:0] SCAN_RST  = 8'hff;
  localparam logic [7:0] CARR_RST  = 8'h03;
  localparam logic [7:0] DIR_RST   = 8'h26;
  localparam logic [7:0] CARR_WMASK = 8'h3f;
  localparam logic [7:0] DIR_WMASK  = 8'h37;
  localparam int DIR_SENSE0 = 0;
  localparam int DIR_SCAN   = 1;
  localparam int DIR_LED    = 2;
  localparam int DIR_SPD    = 4;
  localparam int DIR_KPD    = 5;
  localparam int OP_SENSE   = 3;
  localparam logic [2:0] OP_KEY_A  = 3'h0;
  localparam logic [2:0] OP_KEY_B  = 3'h3;
  localparam logic [2:0] OP_KEY_C  = 3'h6;
  localparam logic [2:0] OP_TIMER  = 3'h5;
  localparam logic [1:0] INP_FIXED = 2'h3;
endpackage

/* testbench/key_pins_model.sv */
// Key matrix, key inputs and indicator pin seen from outside the port.
// Assumes the bench commands which keys and pins are held high.
module key_pins_model (
  input  wire logic       rst_n,
  input  wire logic [7:0] scan_out,
  input  wire logic       scan_oe_n,
  input  wire logic       scan_pd,
  input  wire logic [7:0] scan_ext,
  input  wire logic [3:0] key_ext,
  input  wire logic       led_out,
  input  wire logic       led_oe_n,
  input  wire logic       led_ext,
  output logic      [7:0] scan_in,
  output logic      [3:0] key_in,
  output logic            led_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // A released scan line without pull-down floats, so it shows a new value.
  assign scan_in = !scan_oe_n ? scan_out
                 : (scan_pd ? scan_ext : ~scan_out);
  // Keys are held low only while reset is applied and follow the bench once it is released.
  assign key_in = rst_n ? key_ext : 4'h0;
  assign led_in = !led_oe_n ? led_out : led_ext;
endmodule // key_pins_model

/* testbench/tb_key_port_status_unit.sv */
// Self-checking bench for the key port and status flag unit.
// Assumes the pin model stands on the far side of the port pins.
module tb_key_port_status_unit;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, tz = 1'b0;
  logic       status_test_instr = 1'b0, halt = 1'b0, sx = 1'b0, toe = 1'b0, s0 = 1'b0;
  logic       led_ext = 1'b0, led_out, led_oe_n, led_pd, led_in, flag, stby;
  logic       scan_oe_n, scan_pd, key_pd, s0_en, s0_pd;
  logic [1:0] addr = 2'h0;
  logic [3:0] op = 4'h0, key_ext = 4'h0, key_in;
  logic [7:0] wdata = 8'h00, scan_ext = 8'h00, rdata, scan_out, scan_in, carr;
  int         errors = 0, check_count = 0, cycles = 0;

  key_port_status_unit key_port_status_unit_i (.REF_CLK(clk), .RST_N(rst_n),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .STATUS_TEST_INSTR(status_test_instr), .STATUS_TEST_INSTR_OP(op), .HALT(halt), .HALT_OP(op[2:0]),
    .STBY_EXIT(sx), .TMR_ZERO(tz), .TMR_OUT_EN(toe), .SCAN_IN(scan_in),
    .SCAN_OUT(scan_out), .SCAN_OE_N(scan_oe_n), .SCAN_PD(scan_pd),
    .KEY_IN(key_in), .KEY_PD(key_pd), .SENSE0_IN(s0), .SENSE0_EN(s0_en),
    .SENSE0_PD(s0_pd), .LED_IN(led_in), .LED_OUT(led_out),
    .LED_OE_N(led_oe_n), .LED_PD(led_pd), .FLAG(flag), .STBY_ENTER(stby),
    .CARR_CTRL(carr));
  key_pins_model key_pins_model_i (.rst_n(rst_n), .scan_out(scan_out),
    .scan_oe_n(scan_oe_n), .scan_pd(scan_pd), .scan_ext(scan_ext),
    .key_ext(key_ext), .led_out(led_out), .led_oe_n(led_oe_n),
    .led_ext(led_ext), .scan_in(scan_in), .key_in(key_in), .led_in(led_in));

  always #5 clk = ~clk;
  // The tests take under a hundred cycles, so a hang is cut at 3000.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      complete_run();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so look there.
  task automatic rreg(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic ev(input logic [2:0] k, input logic [3:0] o,
                    input logic [1:0] e);
    @(posedge clk);
    {sx, halt, status_test_instr} <= k;
    op <= o;
    @(posedge clk);
    {sx, halt, status_test_instr} <= 3'h0;
    #1 chk({6'h0, flag, stby}, {6'h0, e});
  endtask
  function automatic logic [7:0] pins();
    return {scan_oe_n, scan_pd, key_pd, s0_en, s0_pd, led_oe_n, led_pd,
            led_out};
  endfunction

  task automatic t_regs();
    chk(pins(), 8'h21);
    rreg(2'h3, 8'h26);
    rreg(2'h2, 8'h03);
    rreg(2'h0, 8'hff);
    rreg(2'h1, 8'h0f);
    scan_ext <= 8'h5a;
    wreg(2'h3, 8'h24);
    rreg(2'h0, 8'h5a);
    chk(pins(), 8'he1);
    wreg(2'h0, 8'h3c);
    rreg(2'h0, 8'h5a);
    wreg(2'h3, 8'h26);
    rreg(2'h0, 8'h3c);
    key_ext <= 4'h9;
    wreg(2'h3, 8'h31);
    rreg(2'h1, 8'h93);
    chk(pins(), 8'hff);
    wreg(2'h1, 8'h00);
    rreg(2'h1, 8'h93);
    wreg(2'h3, 8'h30);
    rreg(2'h1, 8'h97);
    wreg(2'h3, 8'hff);
    rreg(2'h3, 8'h37);
    wreg(2'h2, 8'hff);
    rreg(2'h2, 8'h3f);
    chk(carr, 8'h3f);
    $display("test registers done");
  endtask
  task automatic t_flag();
    key_ext <= 4'h2;
    wreg(2'h3, 8'h31);
    ev(3'h1, 4'h0, 2'b10);
    ev(3'h1, 4'h3, 2'b10);
    ev(3'h1, 4'h6, 2'b10);
    ev(3'h1, 4'h1, 2'b00);
    ev(3'h1, 4'h5, 2'b00);
    tz <= 1'b1;
    ev(3'h1, 4'h5, 2'b10);
    {key_ext, s0, tz} <= 6'h02;
    ev(3'h1, 4'h0, 2'b00);
    ev(3'h1, 4'h8, 2'b10);
    s0 <= 1'b0;
    ev(3'h1, 4'h8, 2'b00);
    ev(3'h2, 4'h0, 2'b01);
    key_ext <= 4'h2;
    ev(3'h2, 4'h0, 2'b10);
    key_ext <= 4'h0;
    ev(3'h2, 4'h0, 2'b00);
    ev(3'h5, 4'h0, 2'b10);
    wreg(2'h3, 8'h26);
    toe <= 1'b1;
    rreg(2'h1, 8'h07);
    chk(pins(), 8'h20);
    $display("test status flag done");
  endtask
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_flag();
    complete_run();
  end
endmodule // tb_key_port_status_unit
